// *** verilog/port_power_overcurrent_ctl.sv ***
`timescale 1ns/10ps
`include "port_power_params.svh"

module port_power_overcurrent_ctl (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Port enable sources, bit 0 is port 4
   input wire port_power_pkg::port_vec_t cfg_port_enable_i,
   input wire port_power_pkg::port_vec_t host_port_enable_i,
   // Power control pins, open drain, bit 0 is port 4
   input wire logic port7_power_ctl_i,
   input wire logic port6_power_ctl_i,
   input wire logic port5_power_ctl_i,
   input wire logic port4_power_ctl_i,
   output logic port7_power_ctl_o,
   output logic port6_power_ctl_o,
   output logic port5_power_ctl_o,
   output logic port4_power_ctl_o,
   output logic port7_power_ctl_oe_o,
   output logic port6_power_ctl_oe_o,
   output logic port5_power_ctl_oe_o,
   output logic port4_power_ctl_oe_o,
   output port_power_pkg::port_vec_t pullup_en_o,
   // Status to hub logic
   output port_power_pkg::port_vec_t port_powered_o,
   output port_power_pkg::port_vec_t overcurrent_o,
   output port_power_pkg::port_vec_t overcurrent_evt_o,
   // Upstream bus power
   input wire logic upstream_bus_power_sense_i,
   output logic bus_power_present_o,
   output logic reconnect_req_o
);
   import port_power_pkg::*;

   typedef struct packed {
      port_vec_t enable;
      port_vec_t oc;
      port_vec_t oc_evt;
      // Per-port filter counters, indexed like the port vectors
      count_t [3:0] sense_cnt;
      // Upstream power tracker
      vbus_state_e vb_state;
      count_t vb_cnt;
      logic reconnect;
   } state_s;

   state_s state_r;
   state_s state_nxt;
   port_vec_t pin_in;
   port_vec_t drive_low;
   logic vbus_seen;

   // Pin levels gathered into one vector, bit 0 is port 4
   assign pin_in[0] = port4_power_ctl_i;
   assign pin_in[1] = port5_power_ctl_i;
   assign pin_in[2] = port6_power_ctl_i;
   assign pin_in[3] = port7_power_ctl_i;
   assign vbus_seen = upstream_bus_power_sense_i;

   // Counter steps while the condition holds and restarts when it drops
   function automatic count_t count_step(input count_t cnt, input logic cond);
      count_step = cond ? cnt + 4'h1 : 4'h0;
   endfunction

   // A port is live only while configuration and host both allow it
   function automatic logic port_allowed(input logic cfg_en, input logic host_en);
      port_allowed = cfg_en & host_en;
   endfunction

   // A released pin pulled low by the monitor flags an overcurrent
   function automatic logic pin_faulted(input logic level);
      pin_faulted = ~level;
   endfunction

   // The pin shows a state other than the one now reported
   function automatic logic sense_changed(input logic level, input logic oc_now);
      sense_changed = pin_faulted(level) != oc_now;
   endfunction

   // The new pin level has held long enough to be believed
   function automatic logic sense_settled(input count_t cnt);
      sense_settled = cnt >= `PP_SENSE_STABLE_CYCLES;
   endfunction

   // Upstream power has been missing long enough to count as gone
   function automatic logic vbus_gone(input count_t cnt);
      vbus_gone = cnt >= `PP_VBUS_LOSS_CYCLES;
   endfunction

   // Filter one port's pin and update its overcurrent report
   function automatic void port_update(
      input logic live,
      input logic level,
      input logic oc_now,
      input count_t cnt_now,
      output logic oc_next,
      output logic evt_next,
      output count_t cnt_next
   );
      oc_next = oc_now;
      evt_next = 1'b0;
      cnt_next = 4'h0;
      if (!live) begin
         // A driven pin says nothing about the monitor
         oc_next = 1'b0;
      end else if (sense_changed(level, oc_now)) begin
         if (sense_settled(cnt_now)) begin
            oc_next = pin_faulted(level);
            evt_next = pin_faulted(level);
         end else begin
            cnt_next = count_step(cnt_now, 1'b1);
         end
      end
   endfunction

   // Track upstream power; a return after a full loss asks for a reconnect
   function automatic void vbus_update(
      input vbus_state_e st_now,
      input count_t cnt_now,
      input logic seen,
      output vbus_state_e st_next,
      output count_t cnt_next,
      output logic reconnect_next
   );
      st_next = st_now;
      cnt_next = cnt_now;
      reconnect_next = 1'b0;
      case (st_now)
         VB_ABSENT: begin
            // Power arriving from absent starts a new connection
            if (seen) begin
               st_next = VB_PRESENT;
               reconnect_next = 1'b1;
            end
         end
         VB_PRESENT: begin
            cnt_next = 4'h0;
            if (!seen) begin
               st_next = VB_LOSS;
            end
         end
         VB_LOSS: begin
            // A short dip is ridden out without a reconnect
            cnt_next = count_step(cnt_now, !seen);
            if (seen) begin
               st_next = VB_PRESENT;
            end else if (vbus_gone(cnt_now)) begin
               st_next = VB_ABSENT;
            end
         end
         default: begin
            st_next = VB_ABSENT;
         end
      endcase
   endfunction

   always_comb begin
      state_nxt = state_r;
      state_nxt.oc_evt = 4'h0;
      // Each port is computed from its own bits only
      for (int p = 0; p < `PP_NUM_PORTS; p++) begin
         // Either source may disable the port
         state_nxt.enable[p] = port_allowed(cfg_port_enable_i[p], host_port_enable_i[p]);
         port_update(state_r.enable[p], pin_in[p], state_r.oc[p], state_r.sense_cnt[p],
                     state_nxt.oc[p], state_nxt.oc_evt[p], state_nxt.sense_cnt[p]);
      end
      // Upstream power tracking and reconnect on a return after a full loss
      vbus_update(state_r.vb_state, state_r.vb_cnt, vbus_seen,
                  state_nxt.vb_state, state_nxt.vb_cnt, state_nxt.reconnect);
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         // Pins start driven low, so every port is unpowered out of reset
         state_r <= '0;
         state_r.enable <= `PP_ENABLE_RST;
         state_r.oc <= '0;
         state_r.oc_evt <= '0;
         state_r.sense_cnt <= '0;
         state_r.vb_state <= VB_ABSENT;
         state_r.vb_cnt <= '0;
         state_r.reconnect <= 1'b0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Disabled port: drive low; enabled: release with pull-up
   assign drive_low = ~state_r.enable;
   // The pins are open drain, so the driven value is always low
   assign port4_power_ctl_o = 1'b0;
   assign port5_power_ctl_o = 1'b0;
   assign port6_power_ctl_o = 1'b0;
   assign port7_power_ctl_o = 1'b0;
   assign port4_power_ctl_oe_o = drive_low[0];
   assign port5_power_ctl_oe_o = drive_low[1];
   assign port6_power_ctl_oe_o = drive_low[2];
   assign port7_power_ctl_oe_o = drive_low[3];

   // The pull-up on a released pin is what turns the external switch on
   assign pullup_en_o[0] = state_r.enable[0];
   assign pullup_en_o[1] = state_r.enable[1];
   assign pullup_en_o[2] = state_r.enable[2];
   assign pullup_en_o[3] = state_r.enable[3];
   assign port_powered_o = state_r.enable & pin_in;

   // Status to the hub logic
   assign overcurrent_o = state_r.oc;
   assign overcurrent_evt_o = state_r.oc_evt;

   assign bus_power_present_o = state_r.vb_state != VB_ABSENT;
   assign reconnect_req_o = state_r.reconnect;
endmodule

// *** verilog/port_power_params.svh ***
`ifndef PORT_POWER_PARAMS_SVH
`define PORT_POWER_PARAMS_SVH

// Number of downstream ports handled here (ports 4 to 7)
`define PP_NUM_PORTS 4
// Number of the first port handled here, which sits at index 0 of the per-port vectors
`define PP_FIRST_PORT 4
// Sense input must hold a new level 4 cycles (this value plus 1) before it is believed
`define PP_SENSE_STABLE_CYCLES 4'h3
// Loss count limit; upstream bus power must stay lost 4 cycles (this value plus 2) before its return requests a reconnect
`define PP_VBUS_LOSS_CYCLES 4'h2
// Reset value of each port's enable vector
`define PP_ENABLE_RST 4'h0

`endif

// *** verilog/port_power_pkg.sv ***
package port_power_pkg;
   typedef logic [3:0] port_vec_t;
   typedef logic [3:0] count_t;

   typedef enum logic [1:0] {
      VB_ABSENT,
      VB_PRESENT,
      VB_LOSS
   } vbus_state_e;
endpackage

// *** verification/port_power_props.sv ***
`timescale 1ns/10ps
module port_power_props (
   // Clock, reset, enables and pins
   input wire logic mclk_i, rstn_i, port4_power_ctl_i, port4_power_ctl_o,
   input wire logic port4_power_ctl_oe_o, port7_power_ctl_oe_o,
   input wire port_power_pkg::port_vec_t cfg_port_enable_i, host_port_enable_i,
   input wire port_power_pkg::port_vec_t pullup_en_o, overcurrent_o, overcurrent_evt_o,
   // Upstream bus power
   input wire logic upstream_bus_power_sense_i, bus_power_present_o, reconnect_req_o
);
   import port_power_pkg::*;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rstn_i);
   en_follow_a: assert property ($past(rstn_i) |->
      pullup_en_o == $past(cfg_port_enable_i & host_port_enable_i)) else $error("enable");
   drive_sel_a: assert property ({port7_power_ctl_oe_o, port4_power_ctl_oe_o} ==
      ~{pullup_en_o[3], pullup_en_o[0]}) else $error("drive");
   drive_low_a: assert property (!port4_power_ctl_o) else $error("level");
   oc_set_a: assert property ((pullup_en_o[0] && !port4_power_ctl_i) [*8] |->
      overcurrent_o[0]) else $error("oc set");
   oc_clr_a: assert property (!pullup_en_o[0] |-> ##2 !overcurrent_o[0]) else $error("oc");
   evt_pulse_a: assert property (overcurrent_evt_o ==
      (overcurrent_o & ~$past(overcurrent_o))) else $error("event");
   vb_loss_a: assert property (!upstream_bus_power_sense_i [*6] |->
      !bus_power_present_o) else $error("loss");
   vb_reconn_a: assert property (reconnect_req_o == $rose(bus_power_present_o))
      else $error("reconnect");
endmodule
bind port_power_overcurrent_ctl port_power_props PROPS (.*);

// *** verification/power_switch_model.sv ***
`timescale 1ns/10ps
module power_switch_model (
   // Hub drive and pull-up, fault request, pin levels
   input wire logic [3:0] oe_i, pull_i, fault_i,
   output wire logic [3:0] pin_o
);
   // Monitor sinks the pin on fault; board pull-down when not lifted
   assign pin_o = ~oe_i & pull_i & ~fault_i;
endmodule

// *** verification/tb_port_power_overcurrent_ctl.sv ***
`timescale 1ns/10ps
module tb_port_power_overcurrent_ctl;
   import port_power_pkg::*;
   logic mclk_i = 1'h0, rstn_i = 1'h0, upstream_bus_power_sense_i = 1'h0;
   logic port7_power_ctl_o, port6_power_ctl_o, port5_power_ctl_o, port4_power_ctl_o;
   logic port7_power_ctl_oe_o, port6_power_ctl_oe_o, port5_power_ctl_oe_o, port4_power_ctl_oe_o;
   wire logic port7_power_ctl_i, port6_power_ctl_i, port5_power_ctl_i, port4_power_ctl_i;
   port_vec_t cfg_port_enable_i = 4'h0, host_port_enable_i = 4'h0, flt = 4'h0, exp_pu = 4'h0;
   port_vec_t pullup_en_o, port_powered_o, overcurrent_o, overcurrent_evt_o;
   logic bus_power_present_o, reconnect_req_o;
   logic [31:0] seed = 32'h0fe4;
   int miscompares = 0, total_checks = 0, lows[5] = '{6, 2, 8, 4, 3};
   always #10 mclk_i = ~mclk_i;
   port_power_overcurrent_ctl DUT (.*);
   power_switch_model PSW (.oe_i({port7_power_ctl_oe_o, port6_power_ctl_oe_o,
      port5_power_ctl_oe_o, port4_power_ctl_oe_o}), .pull_i(pullup_en_o), .fault_i(flt),
      .pin_o({port7_power_ctl_i, port6_power_ctl_i, port5_power_ctl_i, port4_power_ctl_i}));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      total_checks++;
      if (seen !== want) begin
         miscompares++;
         $display("FAIL %0t saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   initial begin
      cyc(8);
      rstn_i <= 1'h1;
      for (int i = 0; i < 800; i++) begin
         cyc(1);
         seed = xs(seed);
         cfg_port_enable_i <= seed[3:0] | seed[7:4];
         host_port_enable_i <= seed[11:8] | seed[15:12];
         flt <= seed[19:16] & seed[23:20];
         @(negedge mclk_i);
         chk(pullup_en_o, exp_pu);
         chk(port_powered_o, exp_pu & ~flt);
         chk({port7_power_ctl_oe_o, port6_power_ctl_oe_o, port5_power_ctl_oe_o,
            port4_power_ctl_oe_o}, port_vec_t'(~exp_pu));
         chk({port7_power_ctl_o, port6_power_ctl_o, port5_power_ctl_o,
            port4_power_ctl_o}, 8'h00);
         exp_pu = cfg_port_enable_i & host_port_enable_i;
      end
      $display("random test done");
      cyc(1);
      cfg_port_enable_i <= 4'hf;
      host_port_enable_i <= 4'hf;
      flt <= 4'h1;
      cyc(10);
      @(negedge mclk_i);
      chk(overcurrent_o, 8'h01);
      chk(port_powered_o, 8'h0e);
      cyc(1);
      host_port_enable_i <= 4'he;
      cyc(3);
      @(negedge mclk_i);
      chk({port4_power_ctl_oe_o, overcurrent_o}, 8'h10);
      $display("overcurrent test done");
      foreach (lows[k]) begin
         cyc(1);
         upstream_bus_power_sense_i <= 1'h0;
         cyc(lows[k]);
         upstream_bus_power_sense_i <= 1'h1;
         cyc(1);
         @(negedge mclk_i);
         chk({bus_power_present_o, reconnect_req_o}, {7'h01, lows[k] >= 4});
      end
      cyc(1);
      rstn_i <= 1'h0;
      cyc(2);
      @(negedge mclk_i);
      chk({pullup_en_o, bus_power_present_o, port4_power_ctl_oe_o}, 8'h01);
      cyc(1);
      rstn_i <= 1'h1;
      cyc(1);
      @(negedge mclk_i);
      chk({bus_power_present_o, reconnect_req_o}, 8'h03);
      $display("bus power test done");
      finish_test();
   end
endmodule
